// *** hw/fpwt_filter.sv ***
// Integrating glitch filter for the raw pulse input
`timescale 1ns/100ps
`default_nettype none
module fpwt_filter #(
	parameter int LVL_W = fpwt_pkg::LVL_W
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Sampling enable and pulse
	input  wire logic sample_i,
	input  wire logic raw_pulse_input_i,
	// Filtered result
	output var  logic filtered_pulse_o
);

	logic [LVL_W-1:0] level;

	// ****************************************
	// Saturating integrator
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level <= fpwt_pkg::LVL_MIN;
		end else if (sample_i) begin
			if (raw_pulse_input_i && level != fpwt_pkg::LVL_MAX) begin
				level <= level + 1'b1;
			end else if (!raw_pulse_input_i &&
				level != fpwt_pkg::LVL_MIN) begin
				level <= level - 1'b1;
			end
		end
	end

	// ****************************************
	// Output with hysteresis
	// ****************************************
	// Only the end levels move the output, so short glitches die out
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			filtered_pulse_o <= 1'b0;
		end else if (level == fpwt_pkg::LVL_MAX) begin
			filtered_pulse_o <= 1'b1;
		end else if (level == fpwt_pkg::LVL_MIN) begin
			filtered_pulse_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** hw/fpwt_pkg.sv ***
// Shared constants, types and register map of the filtered pulse width timer
package fpwt_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_CTRL  = 8'h34;
	localparam logic [7:0] IDX_CLK   = 8'h35;
	localparam logic [7:0] IDX_HCAP  = 8'h36;
	localparam logic [7:0] IDX_LCAP  = 8'h37;
	localparam logic [7:0] IDX_ISTAT = 8'h38;
	localparam logic [7:0] IDX_IMASK = 8'h39;
	localparam int         IDX_LSB   = 2;
	localparam int         IDX_MSB   = 9;
	localparam int         ADDR_W    = 32;
	localparam int         DATA_W    = 32;

	// ****************************************
	// Control and status register fields
	// ****************************************
	localparam int CS_FLT_BIT = 6;
	localparam int CS_OIE_BIT = 5;
	localparam int CS_HOF_BIT = 4;
	localparam int CS_LOF_BIT = 3;
	localparam int CS_ESL_LSB = 1;
	localparam int CS_EDF_BIT = 0;

	// ****************************************
	// Clock select fields
	// ****************************************
	localparam int CK_CNT_LSB = 2;
	localparam int CK_FLT_LSB = 0;

	// ****************************************
	// Interrupt status and mask fields
	// ****************************************
	localparam int         IS_EDGE_BIT = 0;
	localparam int         IS_LOF_BIT  = 1;
	localparam int         IS_HOF_BIT  = 2;
	localparam logic [2:0] IMASK_RST   = 3'h7;

	// ****************************************
	// Counter, filter and divider constants
	// ****************************************
	localparam int         CNT_W     = 8;
	localparam logic [7:0] CNT_CLEAR = 8'h00;
	localparam logic [7:0] CAP_RST   = 8'h00;
	localparam int         LVL_W     = 3;
	localparam logic [2:0] LVL_MIN   = 3'h0;
	localparam logic [2:0] LVL_MAX   = 3'h6;
	localparam int         DIV_BASE  = 1;
	localparam int         PRESC_W   = 5;
	localparam int         NUM_CLKS  = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ESEL_OFF  = 2'b00,
		ESEL_RISE = 2'b01,
		ESEL_FALL = 2'b10,
		ESEL_BOTH = 2'b11
	} fpwt_esel_e;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01,
		BUS_DONE = 2'b10
	} fpwt_bus_e;

	typedef struct packed {
		logic       oie;
		fpwt_esel_e esel;
	} fpwt_ctrl_s;

	typedef struct packed {
		logic [1:0] cnt_sel;
		logic [1:0] flt_sel;
	} fpwt_clk_s;

	typedef struct packed {
		logic high_level_overflow_flag;
		logic low_level_overflow_flag;
		logic edge_f;
	} fpwt_flags_s;

endpackage

// *** hw/fpwt_top.sv ***
// Filtered pulse width timer with AHB-Lite register slave
//
// Overview of operation
// - Rising select: latch low capture, clear counter
// - Falling select: latch high capture, clear counter
// - Both: rise to low, fall to high
// - Nonzero edge select enables edge interrupt
// - Edge requests repeat until select is off
// - Overflow sets low or high flag by level
// - Overflow enable gates overflow flags onto request
// - One shared request; software reads flag bits
// - Filter integrates samples, saturating zero to six
// - Output low at zero, high at six
// - Eight-bit counter, read-only capture registers
// - Writing zero to control clears flag, one keeps it
// - Two-bit selects for count and filter clocks
// - Read-only bit shows filtered pulse level
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fpwt_top #(
	parameter int CNT_W   = fpwt_pkg::CNT_W,
	parameter int PRESC_W = fpwt_pkg::PRESC_W
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output var  logic [31:0] hrdata_o,
	output var  logic        hreadyout_o,
	output var  logic        hresp_o,
	// Pulse input
	input  wire logic        raw_pulse_input_i,
	// Interrupt
	output var  logic        shared_timer_irq_o
);

	// ****************************************
	// Declarations
	// ****************************************
	fpwt_pkg::fpwt_bus_e   state;
	fpwt_pkg::fpwt_bus_e   next_state;
	fpwt_pkg::fpwt_ctrl_s  ctrl;
	fpwt_pkg::fpwt_clk_s   clk_sel;
	fpwt_pkg::fpwt_flags_s flags;
	logic [2:0]            irq_mask;
	logic [7:0]            idx_q;
	logic                  hit_q;
	logic                  wr_q;
	logic                  accept;
	logic                  wr_en;
	logic [31:0]           rd_val;
	logic [PRESC_W-1:0]    presc;
	logic [fpwt_pkg::NUM_CLKS-1:0] tick;
	logic                  cnt_tick;
	logic                  flt_tick;
	logic [CNT_W-1:0]      cnt;
	logic [CNT_W-1:0]      low_width_capture;
	logic [CNT_W-1:0]      high_width_capture;
	logic                  filtered_pulse;
	logic                  filt_prev;
	logic                  rise;
	logic                  fall;
	logic                  rise_sel;
	logic                  fall_sel;
	logic                  edge_evt;
	logic                  ovf_evt;
	logic                  wr_ctrl;
	logic                  wr_clk;
	logic                  wr_istat;
	logic                  wr_imask;
	logic                  clr_edge;
	logic                  clr_lof;
	logic                  clr_hof;
	logic                  edge_irq;
	logic                  ovf_irq;

	// ****************************************
	// Decode helpers
	// ****************************************
	// True when a registered index names the given register
	function automatic logic is_reg(
		input logic       hit,
		input logic [7:0] idx,
		input logic [7:0] want
	);
		is_reg = hit && (idx == want);
	endfunction

	// ****************************************
	// Bus slave state machine
	// ****************************************
	// One wait state per transfer so read data always leaves a flop
	assign accept = hsel_i && hready_i && htrans_i[1];

	always_comb begin
		next_state = state;
		case (state)
			fpwt_pkg::BUS_IDLE: begin
				if (accept) begin
					next_state = fpwt_pkg::BUS_WAIT;
				end
			end
			fpwt_pkg::BUS_WAIT: begin
				next_state = fpwt_pkg::BUS_DONE;
			end
			fpwt_pkg::BUS_DONE: begin
				if (accept) begin
					next_state = fpwt_pkg::BUS_WAIT;
				end else begin
					next_state = fpwt_pkg::BUS_IDLE;
				end
			end
			default: begin
				next_state = fpwt_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= fpwt_pkg::BUS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Address phase capture; upper address bits must be zero to hit
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_q <= 8'h00;
			hit_q <= 1'b0;
			wr_q  <= 1'b0;
		end else if (accept) begin
			idx_q <= haddr_i[fpwt_pkg::IDX_MSB:fpwt_pkg::IDX_LSB];
			hit_q <= (haddr_i[31:fpwt_pkg::IDX_MSB+1] == '0) &&
				(haddr_i[1:0] == 2'b00);
			wr_q  <= hwrite_i;
		end
	end

	assign hreadyout_o = (state != fpwt_pkg::BUS_WAIT);
	assign hresp_o     = 1'b0;
	assign wr_en       = (state == fpwt_pkg::BUS_DONE) && wr_q;
	assign wr_ctrl  = wr_en && is_reg(hit_q, idx_q, fpwt_pkg::IDX_CTRL);
	assign wr_clk   = wr_en && is_reg(hit_q, idx_q, fpwt_pkg::IDX_CLK);
	assign wr_istat = wr_en && is_reg(hit_q, idx_q, fpwt_pkg::IDX_ISTAT);
	assign wr_imask = wr_en && is_reg(hit_q, idx_q, fpwt_pkg::IDX_IMASK);

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rd_val = 32'h0000_0000;
		if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_CTRL)) begin
			rd_val[fpwt_pkg::CS_FLT_BIT] = filtered_pulse;
			rd_val[fpwt_pkg::CS_OIE_BIT] = ctrl.oie;
			rd_val[fpwt_pkg::CS_HOF_BIT] = flags.high_level_overflow_flag;
			rd_val[fpwt_pkg::CS_LOF_BIT] = flags.low_level_overflow_flag;
			rd_val[fpwt_pkg::CS_ESL_LSB+:2] = ctrl.esel;
			rd_val[fpwt_pkg::CS_EDF_BIT] = flags.edge_f;
		end else if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_CLK)) begin
			rd_val[fpwt_pkg::CK_CNT_LSB+:2] = clk_sel.cnt_sel;
			rd_val[fpwt_pkg::CK_FLT_LSB+:2] = clk_sel.flt_sel;
		end else if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_HCAP)) begin
			rd_val[CNT_W-1:0] = high_width_capture;
		end else if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_LCAP)) begin
			rd_val[CNT_W-1:0] = low_width_capture;
		end else if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_ISTAT)) begin
			rd_val[fpwt_pkg::IS_EDGE_BIT] = flags.edge_f;
			rd_val[fpwt_pkg::IS_LOF_BIT]  = flags.low_level_overflow_flag;
			rd_val[fpwt_pkg::IS_HOF_BIT]  = flags.high_level_overflow_flag;
		end else if (is_reg(hit_q, idx_q, fpwt_pkg::IDX_IMASK)) begin
			rd_val[2:0] = irq_mask;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (state == fpwt_pkg::BUS_WAIT && !wr_q) begin
			hrdata_o <= rd_val;
		end
	end

	// ****************************************
	// Software control registers
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl.oie  <= 1'b0;
			ctrl.esel <= fpwt_pkg::ESEL_OFF;
		end else if (wr_ctrl) begin
			ctrl.oie  <= hwdata_i[fpwt_pkg::CS_OIE_BIT];
			ctrl.esel <= fpwt_pkg::fpwt_esel_e'(
				hwdata_i[fpwt_pkg::CS_ESL_LSB+:2]);
		end
	end

	// Reserved and unused bits are dropped and read back as zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_sel <= '0;
		end else if (wr_clk) begin
			clk_sel.cnt_sel <= hwdata_i[fpwt_pkg::CK_CNT_LSB+:2];
			clk_sel.flt_sel <= hwdata_i[fpwt_pkg::CK_FLT_LSB+:2];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask <= fpwt_pkg::IMASK_RST;
		end else if (wr_imask) begin
			irq_mask <= hwdata_i[2:0];
		end
	end

	// ****************************************
	// Clock dividers
	// ****************************************
	// Changing a select does not clear the counter; first period is junk
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			presc <= '0;
		end else begin
			presc <= presc + 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < fpwt_pkg::NUM_CLKS; g++) begin : g_tick
			assign tick[g] = &presc[fpwt_pkg::DIV_BASE+g-1:0];
		end
	endgenerate

	assign cnt_tick = tick[clk_sel.cnt_sel];
	assign flt_tick = tick[clk_sel.flt_sel];

	// ****************************************
	// Filter
	// ****************************************
	fpwt_filter #(
		.LVL_W(fpwt_pkg::LVL_W)
	) u_filter (
		.clk_i            (clk_i),
		.resetn_i         (resetn_i),
		.sample_i         (flt_tick),
		.raw_pulse_input_i(raw_pulse_input_i),
		.filtered_pulse_o (filtered_pulse)
	);

	// ****************************************
	// Edge detection
	// ****************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			filt_prev <= 1'b0;
		end else begin
			filt_prev <= filtered_pulse;
		end
	end

	assign rise     = filtered_pulse && !filt_prev;
	assign fall     = !filtered_pulse && filt_prev;
	assign rise_sel = rise && ctrl.esel[0];
	assign fall_sel = fall && ctrl.esel[1];
	assign edge_evt = rise_sel || fall_sel;

	// ****************************************
	// Width counter and captures
	// ****************************************
	// Capture clear wins over a count tick in the same cycle
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= fpwt_pkg::CNT_CLEAR;
		end else if (edge_evt) begin
			cnt <= fpwt_pkg::CNT_CLEAR;
		end else if (cnt_tick) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign ovf_evt = cnt_tick && !edge_evt && (&cnt);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_width_capture <= fpwt_pkg::CAP_RST;
		end else if (rise_sel) begin
			low_width_capture <= cnt;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			high_width_capture <= fpwt_pkg::CAP_RST;
		end else if (fall_sel) begin
			high_width_capture <= cnt;
		end
	end

	// ****************************************
	// Event flags
	// ****************************************
	// Zero clears through control, one clears through interrupt status
	assign clr_edge = (wr_ctrl && !hwdata_i[fpwt_pkg::CS_EDF_BIT]) ||
		(wr_istat && hwdata_i[fpwt_pkg::IS_EDGE_BIT]);
	assign clr_lof  = (wr_ctrl && !hwdata_i[fpwt_pkg::CS_LOF_BIT]) ||
		(wr_istat && hwdata_i[fpwt_pkg::IS_LOF_BIT]);
	assign clr_hof  = (wr_ctrl && !hwdata_i[fpwt_pkg::CS_HOF_BIT]) ||
		(wr_istat && hwdata_i[fpwt_pkg::IS_HOF_BIT]);

	// A new event in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags.edge_f <= 1'b0;
		end else if (edge_evt) begin
			flags.edge_f <= 1'b1;
		end else if (clr_edge) begin
			flags.edge_f <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags.low_level_overflow_flag <= 1'b0;
		end else if (ovf_evt && !filtered_pulse) begin
			flags.low_level_overflow_flag <= 1'b1;
		end else if (clr_lof) begin
			flags.low_level_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags.high_level_overflow_flag <= 1'b0;
		end else if (ovf_evt && filtered_pulse) begin
			flags.high_level_overflow_flag <= 1'b1;
		end else if (clr_hof) begin
			flags.high_level_overflow_flag <= 1'b0;
		end
	end

	// ****************************************
	// Shared interrupt
	// ****************************************
	assign edge_irq = flags.edge_f && irq_mask[fpwt_pkg::IS_EDGE_BIT] &&
		(ctrl.esel != fpwt_pkg::ESEL_OFF);
	assign ovf_irq  = ctrl.oie &&
		((flags.low_level_overflow_flag && irq_mask[fpwt_pkg::IS_LOF_BIT]) ||
		(flags.high_level_overflow_flag && irq_mask[fpwt_pkg::IS_HOF_BIT]));

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shared_timer_irq_o <= 1'b0;
		end else begin
			shared_timer_irq_o <= edge_irq || ovf_irq;
		end
	end

endmodule
`default_nettype wire

// *** verification/filtered_pulse_width_timer_tb_top.sv ***
// Self-checking bench of the filtered pulse width timer
`timescale 1ns/100ps
`default_nettype none
module filtered_pulse_width_timer_tb_top;
	// ****
	// Signals
	// ****
	typedef struct {
		logic        w;
		logic [7:0]  idx;
		logic [31:0] d;
	} fpwt_row_s;
	logic        clk_i;
	logic        resetn_i;
	logic        hsel_i;
	logic        hwrite_i;
	logic [1:0]  htrans_i;
	logic [2:0]  hsize_i;
	logic [31:0] haddr_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        irq;
	logic        raw;
	logic        run;
	logic        idle_lvl;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic        rdy_s;
	logic        irq_s;
	logic [31:0] rd_s;
	logic [31:0] rv;
	int          fails;
	int          n_compared;
	int          cyc;
	fpwt_row_s   rows [11] = '{
		'{1'b0, fpwt_pkg::IDX_CTRL, 32'h0},
		'{1'b0, fpwt_pkg::IDX_CLK, 32'h0},
		'{1'b0, fpwt_pkg::IDX_HCAP, 32'h0},
		'{1'b0, fpwt_pkg::IDX_LCAP, 32'h0},
		'{1'b0, fpwt_pkg::IDX_ISTAT, 32'h0},
		'{1'b0, fpwt_pkg::IDX_IMASK, 32'h0000_0007},
		'{1'b1, fpwt_pkg::IDX_CLK, 32'h0000_00FF},
		'{1'b0, fpwt_pkg::IDX_CLK, 32'h0000_000F},
		'{1'b1, fpwt_pkg::IDX_HCAP, 32'h0000_00FF},
		'{1'b0, fpwt_pkg::IDX_HCAP, 32'h0},
		'{1'b1, fpwt_pkg::IDX_CLK, 32'h0}};
	// ****
	// Design and pulse source
	// ****
	fpwt_top DUT (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hreadyout_o),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(),
		.raw_pulse_input_i(raw),
		.shared_timer_irq_o(irq)
	);
	fpwt_pulse_src u_src (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(run),
		.idle_lvl_i(idle_lvl),
		.hi_len_i(hi_len),
		.lo_len_i(lo_len),
		.raw_pulse_input_o(raw)
	);
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Sampling mid-cycle keeps reads clear of the edge updates
	always @(negedge clk_i) begin
		rdy_s = hreadyout_o;
		rd_s = hrdata_o;
		irq_s = irq;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			fails++;
			tally_and_finish();
		end
	end
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {22'h0, idx, 2'b00};
		hwrite_i <= w;
		do @(posedge clk_i); while (!rdy_s);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge clk_i); while (!rdy_s);
		rv = rd_s;
	endtask
	task automatic ctl(input logic w, input logic [31:0] d);
		xfer(w, fpwt_pkg::IDX_CTRL, d);
	endtask
	task automatic quiet;
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_s}, 32'h0);
	endtask
	task automatic wait_irq(input int n);
		int i;
		i = 0;
		while (irq_s !== 1'b1 && i < n) begin
			@(posedge clk_i);
			i++;
		end
		chk({31'h0, irq_s}, 32'h1);
	endtask
	task automatic clr_wait(input logic [31:0] d);
		ctl(1'b1, d);
		quiet();
		wait_irq(300);
	endtask
	// Capture may lose the tick that coincides with the clearing edge
	task automatic in2(input logic [31:0] lo);
		chk({31'h0, rv === lo || rv === lo + 32'h1}, 32'h1);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		{resetn_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
		{run, idle_lvl, fails, n_compared, cyc} = '0;
		hsize_i = 3'b010;
		hi_len = 16'd40;
		lo_len = 16'd40;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		foreach (rows[i]) begin
			xfer(rows[i].w, rows[i].idx, rows[i].d);
			if (!rows[i].w) begin
				chk(rv, rows[i].d);
			end
		end
		xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h40, 32'h0);
		chk(rv, 32'h0);
		run <= 1'b1;
		clr_wait(32'h0000_0002);
		clr_wait(32'h0000_0002);
		ctl(1'b1, 32'h0000_0003);
		ctl(1'b0, 32'h0);
		chk(rv, 32'h0000_0043);
		xfer(1'b0, fpwt_pkg::IDX_LCAP, 32'h0);
		in2(32'd39);
		clr_wait(32'h0000_0004);
		clr_wait(32'h0000_0004);
		ctl(1'b0, 32'h0);
		chk(rv, 32'h0000_0005);
		xfer(1'b0, fpwt_pkg::IDX_HCAP, 32'h0);
		in2(32'd39);
		hi_len <= 16'd30;
		lo_len <= 16'd50;
		clr_wait(32'h0000_0006);
		clr_wait(32'h0000_0006);
		clr_wait(32'h0000_0006);
		xfer(1'b0, fpwt_pkg::IDX_LCAP, 32'h0);
		in2(32'd24);
		xfer(1'b0, fpwt_pkg::IDX_HCAP, 32'h0);
		in2(32'd14);
		run <= 1'b0;
		repeat (40) @(posedge clk_i);
		ctl(1'b1, 32'h0000_0006);
		idle_lvl <= 1'b1;
		repeat (5) @(posedge clk_i);
		idle_lvl <= 1'b0;
		repeat (600) @(posedge clk_i);
		chk({31'h0, irq_s}, 32'h0);
		ctl(1'b0, 32'h0);
		chk(rv, 32'h0000_000E);
		ctl(1'b1, 32'h0000_002E);
		wait_irq(10);
		xfer(1'b0, fpwt_pkg::IDX_ISTAT, 32'h0);
		chk(rv, 32'h0000_0002);
		xfer(1'b1, fpwt_pkg::IDX_IMASK, 32'h0);
		quiet();
		xfer(1'b1, fpwt_pkg::IDX_IMASK, 32'h0000_0007);
		wait_irq(10);
		xfer(1'b1, fpwt_pkg::IDX_ISTAT, 32'h0000_0002);
		quiet();
		idle_lvl <= 1'b1;
		repeat (30) @(posedge clk_i);
		ctl(1'b1, 32'h0000_0020);
		quiet();
		wait_irq(600);
		ctl(1'b0, 32'h0);
		chk(rv, 32'h0000_0070);
		ctl(1'b1, 32'h0);
		quiet();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** verification/fpwt_asserts.sv ***
// Port checks of the filtered pulse width timer
`timescale 1ns/100ps
`default_nettype none
module fpwt_asserts #(
	parameter int CNT_W   = fpwt_pkg::CNT_W,
	parameter int PRESC_W = fpwt_pkg::PRESC_W
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        resetn_i,
	// Bus
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	// Pulse and interrupt
	input wire logic        raw_pulse_input_i,
	input wire logic        shared_timer_irq_o
);
	// ****
	// Bus tracking
	// ****
	logic        tk;
	logic        pv;
	logic        pw;
	logic [31:0] pa;
	logic        done;
	logic        miss;
	logic [1:0]  esel_sh;
	logic        oie_sh;
	assign tk   = hsel_i & hready_i & htrans_i[1];
	assign done = pv & hreadyout_o;
	assign miss = pa[1:0] != 2'b00 || pa[31:10] != 22'h0 ||
		pa[9:2] < fpwt_pkg::IDX_CTRL || pa[9:2] > fpwt_pkg::IDX_IMASK;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pv <= 1'b0;
			pw <= 1'b0;
			pa <= 32'h0000_0000;
		end else if (tk) begin
			pv <= 1'b1;
			pw <= hwrite_i;
			pa <= haddr_i;
		end else if (hreadyout_o) begin
			pv <= 1'b0;
		end
	end
	// Shadow of the enables, so irq can be tied to its causes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			esel_sh <= 2'b00;
			oie_sh <= 1'b0;
		end else if (done && pw && pa == {22'h0, fpwt_pkg::IDX_CTRL, 2'b00}) begin
			esel_sh <= hwdata_i[2:1];
			oie_sh <= hwdata_i[5];
		end
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	okay_resp_a: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
	one_wait_a: assert property (tk |=> !hreadyout_o ##1 hreadyout_o)
		else $error("wait state not exactly one cycle");
	wait_cause_a: assert property ($fell(hreadyout_o) |-> $past(tk))
		else $error("wait state without a transfer");
	rdata_hold_a: assert property (hreadyout_o |=> $stable(hrdata_o))
		else $error("read data moved outside a read");
	unmapped_zero_a: assert property (done && !pw && miss |-> hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	irq_quiet_a: assert property (
		(esel_sh == 2'b00 && !oie_sh) [*3] |-> !shared_timer_irq_o)
		else $error("irq with both causes disabled");
	irq_cause_a: assert property (
		$rose(shared_timer_irq_o) |-> $past(esel_sh != 2'b00 || oie_sh))
		else $error("irq rose without an enabled cause");
	irq_sticky_a: assert property (
		shared_timer_irq_o && !$past(done) |=> shared_timer_irq_o)
		else $error("irq dropped without a register write");
	rd_cov_c: cover property (done && !pw);
	wr_cov_c: cover property (done && pw);
	irq_cov_c: cover property ($rose(shared_timer_irq_o));
endmodule
bind fpwt_top fpwt_asserts #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) u_chk (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.hsel_i(hsel_i),
	.haddr_i(haddr_i),
	.htrans_i(htrans_i),
	.hwrite_i(hwrite_i),
	.hsize_i(hsize_i),
	.hwdata_i(hwdata_i),
	.hready_i(hready_i),
	.hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o),
	.raw_pulse_input_i(raw_pulse_input_i),
	.shared_timer_irq_o(shared_timer_irq_o)
);
`default_nettype wire

// *** verification/fpwt_pulse_src.sv ***
// Behavioural model of the external pulse source feeding the timer
`timescale 1ns/100ps
`default_nettype none
module fpwt_pulse_src (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Wave control
	input  wire logic        run_i,
	input  wire logic        idle_lvl_i,
	input  wire logic [15:0] hi_len_i,
	input  wire logic [15:0] lo_len_i,
	// Pulse out
	output var  logic        raw_pulse_input_o
);
	// ****
	// Square wave or held level
	// ****
	logic [15:0] cnt;
	logic [15:0] len;
	assign len = raw_pulse_input_o ? hi_len_i : lo_len_i;
	// Held level lets the bench make glitches and steady levels
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= 16'h0000;
			raw_pulse_input_o <= 1'b0;
		end else if (!run_i) begin
			cnt <= 16'h0000;
			raw_pulse_input_o <= idle_lvl_i;
		end else if (cnt >= len - 16'h0001) begin
			cnt <= 16'h0000;
			raw_pulse_input_o <= !raw_pulse_input_o;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire
